// ===== hw/bst_pkg.sv
// shared constants, state enumeration and state carriers of the boundary scan tap
// assumes: included ahead of every bst_ module, nothing else needed
`default_nettype none

package bst_pkg;

  // instruction register width and codes
  localparam int         BST_IR_W       = 3;
  localparam logic [2:0] BST_IR_EXTEST  = 3'h0;
  localparam logic [2:0] BST_IR_IDCODE  = 3'h1;
  localparam logic [2:0] BST_IR_SAMPLE  = 3'h2;
  localparam logic [2:0] BST_IR_CLAMP   = 3'h3;
  localparam logic [2:0] BST_IR_HIGHZ   = 3'h4;
  localparam logic [2:0] BST_IR_BYPASS  = 3'h7;
  // fixed pattern loaded into the instruction shift stages in capture-ir
  localparam logic [2:0] BST_IR_CAPTURE = 3'h1;
  // instruction current after reset and throughout test-logic-reset
  localparam logic [2:0] BST_IR_RESET   = BST_IR_IDCODE;

  // identification word layout
  localparam int BST_ID_W        = 32;
  localparam int BST_ID_FIXED    = 0;
  localparam int BST_ID_MAKER_LO = 1;
  localparam int BST_ID_MAKER_W  = 11;
  localparam int BST_ID_PART_LO  = 12;
  localparam int BST_ID_PART_W   = 16;
  localparam int BST_ID_REV_LO   = 28;
  localparam int BST_ID_REV_W    = 4;

  // value a bypass stage captures
  localparam logic BST_BYPASS_CAPTURE = 1'b0;
  // reset value of shift stages and parallel latches
  localparam logic [31:0] BST_ZERO_WORD = 32'h0000_0000;

  // tap controller states
  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SHIFT_DR, BST_EXIT1_DR, BST_PAUSE_DR, BST_EXIT2_DR,
    BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SHIFT_IR, BST_EXIT1_IR, BST_PAUSE_IR, BST_EXIT2_IR, BST_UPD_IR
  } bst_state_e;

  // data register picked by the current instruction
  typedef enum logic [1:0] {BST_SEL_BSR, BST_SEL_ID, BST_SEL_BYP} bst_sel_e;

  // state moved on rising test clock edges
  typedef struct packed {
    bst_state_e  state;
    logic [2:0]  ir_shift;
    logic        bypass;
    logic [31:0] id_shift;
  } bst_rise_s;

  // state moved on falling test clock edges
  typedef struct packed {
    logic [2:0]  ir_latch;
    logic [31:0] id_latch;
    logic        tdo;
    logic        tdo_oe;
    logic        mode_drive;
    logic        mode_hz;
    logic        upd_toggle;
  } bst_fall_s;

endpackage : bst_pkg

`default_nettype wire

// ===== hw/bst_sync.sv
// two flip-flop level synchroniser, parameterised width
// assumes: each bit is an independent level, or a word held stable long enough
`default_nettype none

module bst_sync
  import bst_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;   // metastable catcher, read only by s2
    logic [W-1:0] s2;   // settled copy
  } bst_sync_s;

  bst_sync_s sync_reg;  // registered state
  bst_sync_s sync_next; // next state

  // shift the level through two stages
  always_comb
  begin
    sync_next    = sync_reg;
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
  end

  // async reset to zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sync_reg <= '0;
    else
      sync_reg <= sync_next;
  end

  assign q = sync_reg.s2;

endmodule : bst_sync

`default_nettype wire

// ===== hw/bst_bsr.sv
// boundary scan register: shift stages on rising, parallel latches on falling test clock
// assumes: enables are decoded by the tap controller in the same test clock domain
`default_nettype none

module bst_bsr
  import bst_pkg::*;
#(
  parameter int LEN = 24
)
(
  input  wire logic           tck,
  input  wire logic           rst,
  input  wire logic           capture_en,
  input  wire logic           shift_en,
  input  wire logic           update_en,
  input  wire logic           serial_in,
  input  wire logic [LEN-1:0] capture_d,
  output logic                serial_lsb,
  output logic      [LEN-1:0] par_q
);

  logic [LEN-1:0] sh_reg;   // shift stages
  logic [LEN-1:0] sh_next;  // next shift stages
  logic [LEN-1:0] par_reg;  // parallel output latches
  logic [LEN-1:0] par_next; // next latches

  // capture pin values or shift one stage toward serial out
  always_comb
  begin
    sh_next = sh_reg;
    if (capture_en)
      sh_next = capture_d;
    else if (shift_en)
      sh_next = {serial_in, sh_reg[LEN-1:1]};
  end

  // latches move only in update-dr, so shifting never reaches the pins
  always_comb
  begin
    par_next = par_reg;
    if (update_en)
      par_next = sh_reg;
  end

  // rising edge side
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      sh_reg <= '0;
    else
      sh_reg <= sh_next;
  end

  // falling edge side
  always_ff @(negedge tck or posedge rst)
  begin
    if (rst)
      par_reg <= '0;
    else
      par_reg <= par_next;
  end

  assign serial_lsb = sh_reg[0];
  assign par_q      = par_reg;

endmodule : bst_bsr

`default_nettype wire

// ===== hw/bst_tap.sv
// ieee 1149.1 test access port with instruction, bypass, identification and boundary registers
// assumes: test_clock_in is a clock port from the external tester, pads sit behind this block
//
// Summary of operation
// - update-dr falling edge copies shift stages to latches
// - select-ir holds registers, tms low goes capture-ir
// - capture-ir loads fixed pattern, then exit1 or shift
// - shift-ir shifts instruction toward serial out
// - instruction latch and test registers hold while shifting
// - exit1-ir: low to pause, high to update
// - pause-ir waits while low, high to exit2
// - exit2-ir: high to update, low to shift
// - update-ir falling edge latches new instruction
// - update-ir: low to idle, high to select-dr
// - sample 010, extest 000 boundary; bypass 111
// - clamp 011, highz 100 bypass; idcode 001 identification
// - sample captures pins, preload shifts, core undisturbed
// - bypass uses one stage, core unaffected
// - extest drives pins from boundary latches
// - clamp holds outputs at boundary latches
// - highz floats outputs, bypass in path
// - idcode captures identification word in capture-dr
// - test-logic-reset forces idcode instruction
// - 32-bit identification word with fixed one lsb
// - one boundary cell per control and io cell
// - power-up in test-logic-reset with idcode current
// - shift-dr advances selected register only
// - select-dr: low to capture-dr, high to select-ir
`default_nettype none

module bst_tap
  import bst_pkg::*;
#(
  parameter int          NUM_IO   = 8,        // bidirectional functional pins
  parameter logic [10:0] ID_MAKER = 11'h2B5,  // arbitrary value
  parameter logic [15:0] ID_PART  = 16'h5A3C, // arbitrary value
  parameter logic [3:0]  ID_REV   = 4'h1      // arbitrary value
)
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              test_clock_in,
  input  wire logic              test_reset_n,
  input  wire logic              test_mode_select_in,
  input  wire logic              test_serial_in,
  output logic                   test_serial_out,
  output logic                   test_serial_out_oe,
  input  wire logic [NUM_IO-1:0] core_out,
  input  wire logic [NUM_IO-1:0] core_oe,
  output logic      [NUM_IO-1:0] core_in,
  input  wire logic [NUM_IO-1:0] pad_in,
  output logic      [NUM_IO-1:0] pad_out,
  output logic      [NUM_IO-1:0] pad_oe
);

  // one input, one output and one control cell per pin
  localparam int BSR_LEN = 3 * NUM_IO;

  // system clock domain state
  typedef struct packed {
    logic              tgl_seen;  // last settled update toggle
    logic [NUM_IO-1:0] bs_out;    // boundary output latches, clk copy
    logic [NUM_IO-1:0] bs_oe;     // boundary control latches, clk copy
    logic [NUM_IO-1:0] pad_out;   // registered pad value
    logic [NUM_IO-1:0] pad_oe;    // registered pad enable
  } bst_clk_s;

  bst_rise_s rise_reg;   // test clock rising side
  bst_rise_s rise_next;
  bst_fall_s fall_reg;   // test clock falling side
  bst_fall_s fall_next;
  bst_clk_s  clk_reg;    // system clock side
  bst_clk_s  clk_next;

  logic                tap_rst;      // test domain async reset
  logic                tms;          // mode select, already tester-timed
  logic                tdi;          // serial in
  bst_sel_e            sel;          // selected data register
  logic [BST_ID_W-1:0] id_word;      // identification word
  logic                bsr_lsb;      // boundary chain serial out
  logic [BSR_LEN-1:0]  bsr_par;      // boundary parallel latches
  logic [BSR_LEN-1:0]  bsr_cap;      // boundary capture word
  logic [BSR_LEN-1:0]  pins_tck;     // pin view synchronised to test clock
  logic [NUM_IO-1:0]   pad_in_clk;   // pad inputs synchronised to clk
  logic [2:0]          mode_clk;     // drive, highz, toggle in clk domain
  logic                in_shift_dr;  // shift-dr, any selected register
  logic                in_cap_dr;    // capture-dr

  // power-up or tester reset both land in test-logic-reset
  assign tap_rst = sys_rst | ~test_reset_n;
  assign tms     = test_mode_select_in;
  assign tdi     = test_serial_in;

  // decode current instruction to a data register
  always_comb
  begin
    unique case (fall_reg.ir_latch)
      BST_IR_SAMPLE, BST_IR_EXTEST: sel = BST_SEL_BSR;
      BST_IR_IDCODE:                sel = BST_SEL_ID;
      default:                      sel = BST_SEL_BYP;
    endcase
  end

  // identification word assembly
  always_comb
  begin
    id_word                                   = BST_ZERO_WORD;
    id_word[BST_ID_FIXED]                     = 1'b1;
    id_word[BST_ID_MAKER_LO +: BST_ID_MAKER_W] = ID_MAKER;
    id_word[BST_ID_PART_LO +: BST_ID_PART_W]   = ID_PART;
    id_word[BST_ID_REV_LO +: BST_ID_REV_W]     = ID_REV;
  end

  assign in_cap_dr   = rise_reg.state == BST_CAP_DR;
  assign in_shift_dr = rise_reg.state == BST_SHIFT_DR;
  // capture word: inputs low, outputs middle, controls high
  assign bsr_cap     = pins_tck;

  // pin values seen from the test clock; stale by two test clocks at most
  bst_sync #(.W(BSR_LEN)) u_pin_sync (
    .clk (test_clock_in),
    .rst (tap_rst),
    .d   ({clk_reg.pad_oe, clk_reg.pad_out, pad_in}),
    .q   (pins_tck)
  );

  // boundary scan register
  bst_bsr #(.LEN(BSR_LEN)) u_bsr (
    .tck        (test_clock_in),
    .rst        (tap_rst),
    .capture_en (in_cap_dr && sel == BST_SEL_BSR),
    .shift_en   (in_shift_dr && sel == BST_SEL_BSR),
    .update_en  (rise_reg.state == BST_UPD_DR && sel == BST_SEL_BSR),
    .serial_in  (tdi),
    .capture_d  (bsr_cap),
    .serial_lsb (bsr_lsb),
    .par_q      (bsr_par)
  );

  // rising edge: controller state and serial shift stages
  always_comb
  begin
    rise_next = rise_reg;
    unique case (rise_reg.state)
      BST_TLR:      rise_next.state = tms ? BST_TLR : BST_RTI;
      BST_RTI:      rise_next.state = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR:   rise_next.state = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR:   rise_next.state = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_SHIFT_DR: rise_next.state = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_EXIT1_DR: rise_next.state = tms ? BST_UPD_DR : BST_PAUSE_DR;
      BST_PAUSE_DR: rise_next.state = tms ? BST_EXIT2_DR : BST_PAUSE_DR;
      BST_EXIT2_DR: rise_next.state = tms ? BST_UPD_DR : BST_SHIFT_DR;
      BST_UPD_DR:   rise_next.state = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR:   rise_next.state = tms ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR:   rise_next.state = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_SHIFT_IR: rise_next.state = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_EXIT1_IR: rise_next.state = tms ? BST_UPD_IR : BST_PAUSE_IR;
      BST_PAUSE_IR: rise_next.state = tms ? BST_EXIT2_IR : BST_PAUSE_IR;
      BST_EXIT2_IR: rise_next.state = tms ? BST_UPD_IR : BST_SHIFT_IR;
      BST_UPD_IR:   rise_next.state = tms ? BST_SEL_DR : BST_RTI;
    endcase
    // instruction shift stages; all other states hold them
    if (rise_reg.state == BST_CAP_IR)
      rise_next.ir_shift = BST_IR_CAPTURE;
    else if (rise_reg.state == BST_SHIFT_IR)
      rise_next.ir_shift = {tdi, rise_reg.ir_shift[BST_IR_W-1:1]};
    // bypass stage: captures zero, one stage of delay when selected
    if (in_cap_dr && sel == BST_SEL_BYP)
      rise_next.bypass = BST_BYPASS_CAPTURE;
    else if (in_shift_dr && sel == BST_SEL_BYP)
      rise_next.bypass = tdi;
    // identification chain
    if (in_cap_dr && sel == BST_SEL_ID)
      rise_next.id_shift = id_word;
    else if (in_shift_dr && sel == BST_SEL_ID)
      rise_next.id_shift = {tdi, rise_reg.id_shift[BST_ID_W-1:1]};
  end

  always_ff @(posedge test_clock_in or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      rise_reg.state    <= BST_TLR;
      rise_reg.ir_shift <= BST_IR_CAPTURE;
      rise_reg.bypass   <= BST_BYPASS_CAPTURE;
      rise_reg.id_shift <= BST_ZERO_WORD;
    end
    else
      rise_reg <= rise_next;
  end

  // falling edge: instruction latch, id latch, serial out and mode flags
  always_comb
  begin
    fall_next = fall_reg;
    if (rise_reg.state == BST_TLR)
      fall_next.ir_latch = BST_IR_RESET;
    else if (rise_reg.state == BST_UPD_IR)
      fall_next.ir_latch = rise_reg.ir_shift;
    if (rise_reg.state == BST_UPD_DR && sel == BST_SEL_ID)
      fall_next.id_latch = rise_reg.id_shift;
    // serial out only moves on falling edges, floats outside shifting
    fall_next.tdo_oe = 1'b0;
    if (rise_reg.state == BST_SHIFT_IR)
    begin
      fall_next.tdo    = rise_reg.ir_shift[0];
      fall_next.tdo_oe = 1'b1;
    end
    else if (in_shift_dr)
    begin
      fall_next.tdo_oe = 1'b1;
      unique case (sel)
        BST_SEL_BSR: fall_next.tdo = bsr_lsb;
        BST_SEL_ID:  fall_next.tdo = rise_reg.id_shift[0];
        BST_SEL_BYP: fall_next.tdo = rise_reg.bypass;
        default:     fall_next.tdo = rise_reg.bypass;
      endcase
    end
    // pin modes follow the latched instruction, taking effect after update-ir
    fall_next.mode_drive = fall_next.ir_latch == BST_IR_EXTEST ||
                           fall_next.ir_latch == BST_IR_CLAMP;
    fall_next.mode_hz    = fall_next.ir_latch == BST_IR_HIGHZ;
    // toggle tells the clk side that the boundary latches changed
    if (rise_reg.state == BST_UPD_DR && sel == BST_SEL_BSR)
      fall_next.upd_toggle = ~fall_reg.upd_toggle;
  end

  always_ff @(negedge test_clock_in or posedge tap_rst)
  begin
    if (tap_rst)
    begin
      fall_reg.ir_latch   <= BST_IR_RESET;
      fall_reg.id_latch   <= BST_ZERO_WORD;
      fall_reg.tdo        <= 1'b0;
      fall_reg.tdo_oe     <= 1'b0;
      fall_reg.mode_drive <= 1'b0;
      fall_reg.mode_hz    <= 1'b0;
      fall_reg.upd_toggle <= 1'b0;
    end
    else
      fall_reg <= fall_next;
  end

  assign test_serial_out    = fall_reg.tdo;
  assign test_serial_out_oe = fall_reg.tdo_oe;

  // mode flags and update toggle into the clk domain
  bst_sync #(.W(3)) u_mode_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   ({fall_reg.upd_toggle, fall_reg.mode_hz, fall_reg.mode_drive}),
    .q   (mode_clk)
  );

  // pad inputs into the clk domain for the core
  bst_sync #(.W(NUM_IO)) u_pad_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   (pad_in),
    .q   (pad_in_clk)
  );

  // pad mux in clk domain; latches are stable once the toggle is seen
  // limitation: two boundary updates within ~3 clk periods may skip the first
  always_comb
  begin
    clk_next          = clk_reg;
    clk_next.tgl_seen = mode_clk[2];
    if (mode_clk[2] != clk_reg.tgl_seen)
    begin
      clk_next.bs_out = bsr_par[NUM_IO +: NUM_IO];
      clk_next.bs_oe  = bsr_par[2*NUM_IO +: NUM_IO];
    end
    if (mode_clk[1])
    begin
      clk_next.pad_out = '0;
      clk_next.pad_oe  = '0;
    end
    else if (mode_clk[0])
    begin
      clk_next.pad_out = clk_reg.bs_out;
      clk_next.pad_oe  = clk_reg.bs_oe;
    end
    else
    begin
      clk_next.pad_out = core_out;
      clk_next.pad_oe  = core_oe;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      clk_reg <= '0;
    else
      clk_reg <= clk_next;
  end

  // core keeps seeing pins in every mode
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      core_in <= '0;
    else
      core_in <= pad_in_clk;
  end

  assign pad_out = clk_reg.pad_out;
  assign pad_oe  = clk_reg.pad_oe;

  // checks in the test clock domain
  default clocking cb_tck @(posedge test_clock_in);
  endclocking
  default disable iff (tap_rst);

  sequence s_ir_done;
    (rise_reg.state == BST_EXIT1_IR || rise_reg.state == BST_EXIT2_IR) && tms ##1 rise_reg.state == BST_UPD_IR;
  endsequence

  sequence s_id_capture;
    rise_reg.state == BST_CAP_DR && sel == BST_SEL_ID;
  endsequence

  a_sel_ir_step: assert property (rise_reg.state == BST_SEL_IR && !tms |=> rise_reg.state == BST_CAP_IR)
    else $error("select-ir did not move to capture-ir");
  a_cap_ir_load: assert property (rise_reg.state == BST_CAP_IR |=> rise_reg.ir_shift == BST_IR_CAPTURE)
    else $error("capture-ir pattern not loaded");
  a_ir_shift_move: assert property (rise_reg.state == BST_SHIFT_IR |=>
                                    rise_reg.ir_shift == {$past(tdi), $past(rise_reg.ir_shift[2:1])})
    else $error("instruction did not shift one stage");
  a_ir_hold_shift: assert property (rise_reg.state == BST_SHIFT_IR |=>
                                    $stable(fall_reg.ir_latch) && $stable(rise_reg.id_shift))
    else $error("registers moved during instruction shift");
  a_exit1_branch: assert property (rise_reg.state == BST_EXIT1_IR |=>
                                   rise_reg.state == ($past(tms) ? BST_UPD_IR : BST_PAUSE_IR))
    else $error("wrong exit1-ir branch");
  a_pause_ir_wait: assert property (rise_reg.state == BST_PAUSE_IR && !tms |=> rise_reg.state == BST_PAUSE_IR)
    else $error("pause-ir left with mode select low");
  a_exit2_update: assert property (rise_reg.state == BST_EXIT2_IR |=>
                                   rise_reg.state == ($past(tms) ? BST_UPD_IR : BST_SHIFT_IR))
    else $error("wrong exit2-ir branch");
  a_ir_latch_new: assert property (s_ir_done |=> fall_reg.ir_latch == $past(rise_reg.ir_shift))
    else $error("instruction not latched at update-ir");
  a_upd_ir_leave: assert property (rise_reg.state == BST_UPD_IR |=>
                                   rise_reg.state == ($past(tms) ? BST_SEL_DR : BST_RTI))
    else $error("wrong update-ir exit");
  a_tlr_idcode: assert property (rise_reg.state == BST_TLR |=> fall_reg.ir_latch == BST_IR_IDCODE)
    else $error("idcode not forced in test-logic-reset");
  a_id_capture: assert property (s_id_capture |=> rise_reg.id_shift == id_word && rise_reg.id_shift[0])
    else $error("identification word not captured");
  a_bypass_path: assert property (in_shift_dr && sel == BST_SEL_BYP ##1 in_shift_dr |->
                                  test_serial_out == $past(tdi))
    else $error("bypass path is not one stage");
  a_tdo_float: assert property (!(in_shift_dr || rise_reg.state == BST_SHIFT_IR) |-> !test_serial_out_oe)
    else $error("serial out driven outside shift");
  a_sel_dr_step: assert property (rise_reg.state == BST_SEL_DR |=>
                                  rise_reg.state == ($past(tms) ? BST_SEL_IR : BST_CAP_DR))
    else $error("wrong select-dr exit");

endmodule : bst_tap

`default_nettype wire

// ===== verification/bst_tester.sv
// tester model of the external test controller: drives the test port pins
// assumes: test clock (6 ns) runs only inside frames, tdo read before each rise
`default_nettype none

module bst_tester
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // pause walk after the first bit: exit1 -> pause -> pause -> exit2 -> shift
  localparam logic [3:0] PZ = 4'h4;

  // idle levels: clock parked low, reset released
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // one bit: lines set just after the fall, tdo taken once the fall has settled, then one pulse
  // reading tdo in the time step of the falling edge would race the design's update
  task automatic step(input logic m, input logic d, output logic q);
    #1;
    tms = m;
    tdi = d;
    #1 q = tdo;
    #1 tck = 1'b1;
    #3 tck = 1'b0;
    tdi = ~d; // no stale level left on the data line
  endtask : step

  // five high edges always reach test-logic-reset, then on to idle
  task automatic home();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : home

  // async test reset pulse, then walk to idle
  task automatic pulse_reset();
    trst_n = 1'b0;
    #20 trst_n = 1'b1;
    home();
  endtask : pulse_reset

  // idle -> shift, n bits lsb first, optional pause after bit 0, update -> idle
  task automatic scan(input logic ir, input int n, input logic brk, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1 || (brk && i == 0), din[i], q);
      dout[i] = q;
      if (brk && i == 0)
        for (int k = 0; k < 4; k++) step(PZ[k], 1'b0, q);
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : bst_tester

`default_nettype wire

// ===== verification/boundary_scan_tap_tb.sv
// self-checking bench of the boundary scan tap with an integer reference model
// assumes: bst_tester drives the test port; core and pin values set here
`default_nettype none

module boundary_scan_tap_tb
  import bst_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          NIO = 8;
  localparam logic [10:0] MK  = 11'h3C1;  // arbitrary value
  localparam logic [15:0] PT  = 16'h1234; // arbitrary value
  localparam logic [3:0]  RV  = 4'h6;     // arbitrary value
  localparam logic [31:0] IDW = {RV, PT, MK, 1'b1};
  logic           clk, sys_rst, tck, trst_n, tms, tdi, tdo, tdo_oe, tdo_pin;
  logic [NIO-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
  logic [31:0]    din, dout, bsr_last, exp_o, exp_e;
  int             mismatches, n_compared, n;

  bst_tap #(.NUM_IO(NIO), .ID_MAKER(MK), .ID_PART(PT), .ID_REV(RV)) dut (
    .clk(clk), .sys_rst(sys_rst), .test_clock_in(tck), .test_reset_n(trst_n),
    .test_mode_select_in(tms), .test_serial_in(tdi), .test_serial_out(tdo),
    .test_serial_out_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  bst_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_pin));

  // line as the tester sees it: no pull, so a floating line shows the inverse
  assign tdo_pin = tdo_oe ? tdo : ~tdo;

  // system clock, 50 ns
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // compare and count; four-state case equality so x only matches x
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // single exit point of the run
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // watchdog: the sequence needs well under 100 us
  initial
  begin
    #1000000;
    mismatches++;
    conclude();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h172E5B6A));
    sys_rst = 1'b1;
    core_out = NIO'($urandom);
    core_oe = NIO'($urandom);
    pad_in = NIO'($urandom);
    bsr_last = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    #2 sys_rst = 1'b0;
    tester.home();
    check(32'(tdo_oe), 32'h0);
    tester.scan(1'b0, 32, 1'b0, $urandom, dout);
    check(dout, IDW);
    check(32'(core_in), 32'(pad_in));
    $display("test identification after reset done");
    // every code, odd ones through pause-ir and exit2-ir
    for (int c = 0; c < 8; c++)
    begin
      tester.scan(1'b1, 3, c[0], 32'(c), dout);
      check(32'(dout[2:0]), 32'(BST_IR_CAPTURE));
      din = $urandom;
      n = (c == 0 || c == 2) ? 3 * NIO : 32;
      tester.scan(1'b0, n, 1'b0, din, dout);
      if (n < 32)
      begin
        check(32'(dout[NIO-1:0]), 32'(pad_in));
        bsr_last = din;
      end
      else
        check(dout, c == 1 ? IDW : {din[30:0], BST_BYPASS_CAPTURE});
      repeat (6) @(posedge clk);
      #2;
      exp_o = (c == 0 || c == 3) ? 32'(bsr_last[2*NIO-1:NIO]) : (c == 4 ? 32'h0 : 32'(core_out));
      exp_e = (c == 0 || c == 3) ? 32'(bsr_last[3*NIO-1:2*NIO]) : (c == 4 ? 32'h0 : 32'(core_oe));
      check(32'(pad_out), exp_o);
      check(32'(pad_oe), exp_e);
      $display("test instruction %0d done", c);
    end
    tester.pulse_reset();
    tester.scan(1'b0, 32, 1'b0, $urandom, dout);
    check(dout, IDW);
    $display("test async test reset done");
    conclude();
  end
endmodule : boundary_scan_tap_tb

`default_nettype wire
